// >>> fan_tach_thermal_option_regs.sv
`timescale 1ns/100ps
// Operation
// R1 - while locked, option, top-temp and step registers ignore writes
// R2 - enhanced mode refresh code: 00 1 s, 01 twice per second, 1x 300 ms
// R3 - snap bit clear ramps off; set goes off at once on duty 00h
// R4 - enhanced mode guard time 63, 32, 16, 8 ticks of 90 kHz
// R5 - opportunistic off: refresh once per period; on: on each valid reading
// R6 - opportunistic valid reading restarts the refresh period counter
// R7 - shadow status 1 bits 6:4 clear on write-one only when event inactive
// R8 - shadow status 1 bit 7 is read-only; writing one does nothing
// R9 - shadow status registers return to zero on supply-good rising
// R10 - shadow status 2 and 3 bits clear on write-one only when event inactive
// R11 - shadow status never raises an interrupt
// R12 - speed input mode fields at 7:6, 5:4, 3:2: normal, locked high, low
// R13 - tach mode bits 1:0 ignore writes and read zero
// R14 - top-temperature registers default 2Dh, reload on supply-good rising
// R15 - top temperature compared only when zone adjustment enabled
// R16 - reaching top temperature subtracts 2, 4, 6 or 8 degrees from low limit
// R17 - zone 1 remote 1, zone 2 ambient, zone 3 remote 2; step fields 7:6, 5:4
// R18 - software should not write the vendor test registers
// R19 - read-only test register at ADh ignores writes and reads zero
// R20 - per-channel enhanced bit enables guard and refresh fields
// R21 - a set status bit stays until cleared by software or its enable
// R22 - lock input, once seen, blocks lockable writes until reset
module fan_tach_thermal_option_regs
    import fan_opt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        lock_in,
    input  wire logic        supply_good,
    input  wire logic [23:0] event_set,
    input  wire logic [23:0] event_active,
    input  wire logic [23:0] event_enable,
    input  wire logic [2:0]  enhanced_mode,
    input  wire logic [2:0]  valid_reading,
    input  wire logic [2:0]  drive_duty_zero,
    input  wire logic [2:0]  auto_low_limit_adjust,
    input  wire logic [7:0]  temp_zone1,
    input  wire logic [7:0]  temp_zone2,
    input  wire logic [7:0]  temp_zone3,
    output logic      [2:0]  tach_refresh_pulse,
    output logic      [5:0]  guard_ticks_ch1,
    output logic      [5:0]  guard_ticks_ch2,
    output logic      [5:0]  guard_ticks_ch3,
    output logic      [2:0]  snap_off_now,
    output logic      [5:0]  speed_in_mode,
    output logic      [2:0]  low_limit_dec_pulse,
    output logic      [7:0]  low_limit_dec_z1,
    output logic      [7:0]  low_limit_dec_z2,
    output logic      [7:0]  low_limit_dec_z3
);

    logic [7:0]  drive_opt_q [3];
    logic [7:0]  vtest_a_q;
    logic [7:0]  vtest_b_q;
    logic [7:0]  vtest_c_q;
    logic [7:0]  shadow1_q;
    logic [7:0]  shadow2_q;
    logic [7:0]  shadow3_q;
    logic [7:0]  tach_mode_q;
    logic [7:0]  top_z1_q;
    logic [7:0]  top_z2_q;
    logic [7:0]  top_z3_q;
    logic [7:0]  low_step_q;
    logic        lock_meta_q;
    logic        lock_sync_q;
    logic        locked_q;
    logic        pg_meta_q;
    logic        pg_sync_q;
    logic        pg_last_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [2:0]  above_q;
    logic [24:0] per_cnt_q [3];
    logic [2:0]  refresh_q;
    logic [2:0]  dec_q;
    logic [7:0]  dec_z1_q;
    logic [7:0]  dec_z2_q;
    logic [7:0]  dec_z3_q;

    logic        wr_take;
    logic        pg_rise;
    logic [7:0]  wdata;
    logic [2:0]  above_now;
    logic [7:0]  rd_mux;

    // single-cycle ack: waitrequest low the cycle after a request is seen
    assign wr_take = avs_write && ack_q;
    assign wdata   = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    assign pg_rise = pg_sync_q && !pg_last_q;

    // write-one clear, held off while the event is still active
    function automatic logic [7:0] clr_f(input logic [7:0] off, input logic [7:0] mask,
                                         input logic [7:0] active);
        clr_f = (wr_take && avs_address == off) ? (wdata & mask & ~active) : 8'h00;
    endfunction : clr_f

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_q           <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        end
    end

    // synchronisers for lock and supply-good pins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_meta_q <= 1'b0;
            lock_sync_q <= 1'b0;
            locked_q    <= 1'b0;
            pg_meta_q   <= 1'b0;
            pg_sync_q   <= 1'b0;
            pg_last_q   <= 1'b0;
        end
        else
        begin
            lock_meta_q <= lock_in;
            lock_sync_q <= lock_meta_q;
            locked_q    <= locked_q || lock_sync_q; // R22
            pg_meta_q   <= supply_good;
            pg_sync_q   <= pg_meta_q;
            pg_last_q   <= pg_sync_q;
        end
    end

    // lockable configuration registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
                drive_opt_q[i] <= RST_DRIVE_OPTION;
            vtest_a_q  <= RST_VENDOR_TEST_A;
            vtest_b_q  <= RST_VENDOR_TEST_B;
            low_step_q <= RST_LOW_STEP;
        end
        else if (wr_take && !locked_q) // R1
        begin
            unique case (avs_address)
                OFF_DRIVE1_OPTION: drive_opt_q[0] <= wdata & MASK_DRIVE_OPTION;
                OFF_DRIVE2_OPTION: drive_opt_q[1] <= wdata & MASK_DRIVE_OPTION;
                OFF_DRIVE3_OPTION: drive_opt_q[2] <= wdata & MASK_DRIVE_OPTION;
                OFF_VENDOR_TEST_A: vtest_a_q      <= wdata;
                OFF_VENDOR_TEST_B: vtest_b_q      <= wdata;
                OFF_LOW_STEP:      low_step_q     <= wdata & MASK_LOW_STEP;
                default: ;
            endcase
        end
    end

    // top temperatures: lockable, reloaded on supply-good rising
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            top_z1_q <= RST_TOP_TEMP;
            top_z2_q <= RST_TOP_TEMP;
            top_z3_q <= RST_TOP_TEMP;
        end
        else if (pg_rise) // R14
        begin
            top_z1_q <= RST_TOP_TEMP;
            top_z2_q <= RST_TOP_TEMP;
            top_z3_q <= RST_TOP_TEMP;
        end
        else if (wr_take && !locked_q) // R1
        begin
            if (avs_address == OFF_TOP_TEMP_Z1)
                top_z1_q <= wdata;
            if (avs_address == OFF_TOP_TEMP_Z2)
                top_z2_q <= wdata;
            if (avs_address == OFF_TOP_TEMP_Z3)
                top_z3_q <= wdata;
        end
    end

    // not lockable per the map
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vtest_c_q   <= RST_VENDOR_TEST_C;
            tach_mode_q <= RST_TACH_MODE;
        end
        else if (wr_take)
        begin
            if (avs_address == OFF_VENDOR_TEST_C)
                vtest_c_q <= wdata;
            if (avs_address == OFF_TACH_MODE)
                tach_mode_q <= wdata & MASK_TACH_MODE; // R12 R13
        end
    end

    // shadow status: set beats clear; clear only while event inactive
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shadow1_q <= RST_SHADOW_STAT;
            shadow2_q <= RST_SHADOW_STAT;
            shadow3_q <= RST_SHADOW_STAT;
        end
        else if (pg_rise) // R9
        begin
            shadow1_q <= RST_SHADOW_STAT;
            shadow2_q <= RST_SHADOW_STAT;
            shadow3_q <= RST_SHADOW_STAT;
        end
        else
        begin
            shadow1_q <= (shadow1_q & event_enable[7:0] // R21
                & ~clr_f(OFF_SHADOW_STAT_1, MASK_SHADOW_1, event_active[7:0])) // R7 R8
                | (event_set[7:0] & event_enable[7:0]);
            shadow2_q <= (shadow2_q & event_enable[15:8]
                & ~clr_f(OFF_SHADOW_STAT_2, MASK_SHADOW_2, event_active[15:8])) // R10
                | (event_set[15:8] & event_enable[15:8] & MASK_SHADOW_2);
            shadow3_q <= (shadow3_q & event_enable[23:16]
                & ~clr_f(OFF_SHADOW_STAT_3, MASK_SHADOW_3, event_active[23:16])) // R10
                | (event_set[23:16] & event_enable[23:16] & MASK_SHADOW_3);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        unique case (avs_address)
            OFF_DRIVE1_OPTION: rd_mux = drive_opt_q[0];
            OFF_DRIVE2_OPTION: rd_mux = drive_opt_q[1];
            OFF_DRIVE3_OPTION: rd_mux = drive_opt_q[2];
            OFF_VENDOR_TEST_A: rd_mux = vtest_a_q;
            OFF_VENDOR_TEST_B: rd_mux = vtest_b_q;
            OFF_VENDOR_TEST_C: rd_mux = vtest_c_q;
            OFF_VENDOR_TEST_D: rd_mux = RST_VENDOR_TEST_D;
            OFF_SHADOW_STAT_1: rd_mux = shadow1_q;
            OFF_SHADOW_STAT_2: rd_mux = shadow2_q;
            OFF_SHADOW_STAT_3: rd_mux = shadow3_q;
            OFF_TACH_MODE:     rd_mux = tach_mode_q;
            OFF_VENDOR_TEST_E: rd_mux = RST_VENDOR_TEST_E; // R19
            OFF_TOP_TEMP_Z1:   rd_mux = top_z1_q;
            OFF_TOP_TEMP_Z3:   rd_mux = top_z3_q;
            OFF_TOP_TEMP_Z2:   rd_mux = top_z2_q;
            OFF_LOW_STEP:      rd_mux = low_step_q;
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (avs_read && !ack_q)
            rdata_q <= {24'h00_0000, rd_mux};
    end
    assign avs_readdata = rdata_q;

    // refresh-period counters per channel
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
                per_cnt_q[i] <= 25'h0;
            refresh_q <= 3'b000;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                automatic logic [1:0]  sel = drive_opt_q[i][REFRESH_LSB +: 2];
                // 1 s at 25 MHz needs all 25 bits
                automatic logic [24:0] lim = 25'(CYC_PER_MS * REFRESH_MS_1X - 1);
                if (sel == 2'b00)
                    lim = 25'(CYC_PER_MS * REFRESH_MS_00 - 1); // R2
                else if (sel == 2'b01)
                    lim = 25'(CYC_PER_MS * REFRESH_MS_01 - 1);
                refresh_q[i] <= 1'b0;
                if (!enhanced_mode[i]) // R20
                    per_cnt_q[i] <= 25'h0;
                else if (drive_opt_q[i][OPP_BIT] && valid_reading[i]) // R5
                begin
                    per_cnt_q[i] <= 25'h0; // R6
                    refresh_q[i] <= 1'b1;
                end
                else if (per_cnt_q[i] >= lim)
                begin
                    per_cnt_q[i] <= 25'h0;
                    refresh_q[i] <= 1'b1;
                end
                else
                    per_cnt_q[i] <= per_cnt_q[i] + 25'h1;
            end
        end
    end

    // static drive controls
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            guard_ticks_ch1 <= 6'd0;
            guard_ticks_ch2 <= 6'd0;
            guard_ticks_ch3 <= 6'd0;
            snap_off_now    <= 3'b000;
            speed_in_mode   <= 6'd0;
        end
        else
        begin
            guard_ticks_ch1 <= enhanced_mode[0]
                ? guard_ticks_f(drive_opt_q[0][GUARD_LSB +: 2]) : 6'd0; // R4 R20
            guard_ticks_ch2 <= enhanced_mode[1]
                ? guard_ticks_f(drive_opt_q[1][GUARD_LSB +: 2]) : 6'd0;
            guard_ticks_ch3 <= enhanced_mode[2]
                ? guard_ticks_f(drive_opt_q[2][GUARD_LSB +: 2]) : 6'd0;
            for (int i = 0; i < 3; i++)
                snap_off_now[i] <= drive_opt_q[i][SNAP_BIT] && drive_duty_zero[i]; // R3
            speed_in_mode <= {tach_mode_q[SPD1_MODE_LSB +: 2],
                              tach_mode_q[SPD2_MODE_LSB +: 2],
                              tach_mode_q[SPD3_MODE_LSB +: 2]}; // R12
        end
    end

    // top-temperature compare, one decrement per crossing
    assign above_now = {temp_zone3 >= top_z3_q,
                        temp_zone2 >= top_z2_q,
                        temp_zone1 >= top_z1_q} & auto_low_limit_adjust; // R15 R17

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            above_q  <= 3'b000;
            dec_q    <= 3'b000;
            dec_z1_q <= 8'h00;
            dec_z2_q <= 8'h00;
            dec_z3_q <= 8'h00;
        end
        else
        begin
            above_q  <= above_now;
            dec_q    <= above_now & ~above_q; // R16
            dec_z1_q <= step_deg_f(low_step_q[STEP_Z1_LSB +: 2]); // R17
            // zone 2 has no step field; its step is fixed at STEP_DEG_BASE
            dec_z2_q <= STEP_DEG_BASE;
            dec_z3_q <= step_deg_f(low_step_q[STEP_Z3_LSB +: 2]);
        end
    end

    // no interrupt output: shadow copies are visible by read only (R11)
    assign tach_refresh_pulse  = refresh_q;
    assign low_limit_dec_pulse = dec_q;
    assign low_limit_dec_z1    = dec_z1_q;
    assign low_limit_dec_z2    = dec_z2_q;
    assign low_limit_dec_z3    = dec_z3_q;

endmodule : fan_tach_thermal_option_regs

// >>> fan_opt_pkg.sv
package fan_opt_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_DRIVE1_OPTION  = 8'h94;
    localparam logic [7:0] OFF_DRIVE2_OPTION  = 8'h95;
    localparam logic [7:0] OFF_DRIVE3_OPTION  = 8'h96;
    localparam logic [7:0] OFF_VENDOR_TEST_A  = 8'h97;
    localparam logic [7:0] OFF_VENDOR_TEST_B  = 8'h98;
    localparam logic [7:0] OFF_VENDOR_TEST_C  = 8'hA3;
    localparam logic [7:0] OFF_VENDOR_TEST_D  = 8'hA4;
    localparam logic [7:0] OFF_SHADOW_STAT_1  = 8'hA5;
    localparam logic [7:0] OFF_SHADOW_STAT_2  = 8'hA6;
    localparam logic [7:0] OFF_SHADOW_STAT_3  = 8'hA7;
    localparam logic [7:0] OFF_TACH_MODE      = 8'hAB;
    localparam logic [7:0] OFF_VENDOR_TEST_E  = 8'hAD;
    localparam logic [7:0] OFF_TOP_TEMP_Z1    = 8'hAE;
    localparam logic [7:0] OFF_TOP_TEMP_Z3    = 8'hAF;
    localparam logic [7:0] OFF_TOP_TEMP_Z2    = 8'hB3;
    localparam logic [7:0] OFF_LOW_STEP       = 8'hB4;

    // reset values
    localparam logic [7:0] RST_DRIVE_OPTION   = 8'h0C;
    localparam logic [7:0] RST_VENDOR_TEST_A  = 8'h5A;
    localparam logic [7:0] RST_VENDOR_TEST_B  = 8'hF1;
    localparam logic [7:0] RST_VENDOR_TEST_C  = 8'h00;
    localparam logic [7:0] RST_VENDOR_TEST_D  = 8'h02;
    localparam logic [7:0] RST_SHADOW_STAT    = 8'h00;
    localparam logic [7:0] RST_TACH_MODE      = 8'h00;
    localparam logic [7:0] RST_VENDOR_TEST_E  = 8'h00;
    localparam logic [7:0] RST_TOP_TEMP       = 8'h2D;
    localparam logic [7:0] RST_LOW_STEP       = 8'h00;

    // writable-bit masks
    localparam logic [7:0] MASK_DRIVE_OPTION  = 8'h3F;
    localparam logic [7:0] MASK_TACH_MODE     = 8'hFC;
    localparam logic [7:0] MASK_LOW_STEP      = 8'hF0;
    localparam logic [7:0] MASK_SHADOW_1      = 8'h70;
    localparam logic [7:0] MASK_SHADOW_3      = 8'h03;
    localparam logic [7:0] MASK_SHADOW_2      = 8'hDD;

    // drive-option, tach-mode and low-step field positions
    localparam int REFRESH_LSB   = 0;
    localparam int SNAP_BIT      = 2;
    localparam int GUARD_LSB     = 3;
    localparam int OPP_BIT       = 5;
    localparam int SPD1_MODE_LSB = 6;
    localparam int SPD2_MODE_LSB = 4;
    localparam int SPD3_MODE_LSB = 2;
    localparam int STEP_Z1_LSB   = 6;
    localparam int STEP_Z3_LSB   = 4;

    // guard times in 90 kHz ticks
    localparam logic [5:0] GUARD_TICKS_00 = 6'd63;
    localparam logic [5:0] GUARD_TICKS_01 = 6'd32;
    localparam logic [5:0] GUARD_TICKS_10 = 6'd16;
    localparam logic [5:0] GUARD_TICKS_11 = 6'd8;

    // refresh periods in ms
    localparam int REFRESH_MS_00 = 1000;
    localparam int REFRESH_MS_01 = 500;
    localparam int REFRESH_MS_1X = 300;
    localparam int CLK_HZ        = 25_000_000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;

    // step subtracted from low limit, degrees C
    localparam logic [7:0] STEP_DEG_BASE = 8'd2;

    typedef enum logic [1:0]
    {
        SPD_NORMAL      = 2'b00,
        SPD_LOCKED_HIGH = 2'b01,
        SPD_LOCKED_LOW  = 2'b10,
        SPD_UNDEFINED   = 2'b11
    } speed_mode_e;

    typedef struct packed
    {
        logic [1:0] guard_sel;
        logic       snap_off_en;
        logic       opportunistic_sample_en;
        logic [1:0] refresh_sel;
        logic [5:0] guard_ticks;
        logic [4:0] pad;
    } drive_cfg_s;

    function automatic logic [5:0] guard_ticks_f(input logic [1:0] sel);
        unique case (sel)
            2'b00:   guard_ticks_f = GUARD_TICKS_00;
            2'b01:   guard_ticks_f = GUARD_TICKS_01;
            2'b10:   guard_ticks_f = GUARD_TICKS_10;
            default: guard_ticks_f = GUARD_TICKS_11;
        endcase
    endfunction : guard_ticks_f

    function automatic logic [7:0] step_deg_f(input logic [1:0] code);
        step_deg_f = STEP_DEG_BASE + {5'd0, code, 1'b0};
    endfunction : step_deg_f

endpackage : fan_opt_pkg

// >>> fan_tach_thermal_option_regs_asserts.sv
`timescale 1ns/100ps
module fan_opt_asserts
    import fan_opt_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  enhanced_mode,
    input wire logic [5:0]  guard_ticks_ch1,
    input wire logic [2:0]  drive_duty_zero,
    input wire logic [2:0]  snap_off_now,
    input wire logic [2:0]  auto_low_limit_adjust,
    input wire logic [2:0]  low_limit_dec_pulse,
    input wire logic [7:0]  low_limit_dec_z1,
    input wire logic [7:0]  low_limit_dec_z2,
    input wire logic [2:0]  tach_refresh_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ack_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not acknowledged after one wait state");
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge held longer than one cycle");
    a_ack_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("acknowledge without a request");
    a_read_upper_zero: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_guard_mode_one: assert property (
        !enhanced_mode[0] [*2] |-> guard_ticks_ch1 == 6'h00)
        else $error("guard time active in standard mode");
    a_guard_code_legal: assert property (
        guard_ticks_ch1 inside {6'h00, 6'h08, 6'h10, 6'h20, 6'h3F})
        else $error("guard time not one of the coded values");
    a_snap_needs_zero: assert property (
        snap_off_now != 3'h0 |-> (snap_off_now & ~$past(drive_duty_zero)) == 3'h0)
        else $error("snap off without zero duty");
    a_dec_needs_enable: assert property (
        low_limit_dec_pulse != 3'h0 |->
        (low_limit_dec_pulse & ~$past(auto_low_limit_adjust)) == 3'h0)
        else $error("low limit step on a disabled zone");
    a_dec_one_pulse: assert property (low_limit_dec_pulse[0] |=> !low_limit_dec_pulse[0])
        else $error("low limit step pulse longer than one cycle");
    a_dec_zone2_fixed: assert property (low_limit_dec_pulse[1] |-> low_limit_dec_z2 == 8'h02)
        else $error("zone 2 step not two degrees");
    a_dec_zone1_step: assert property (
        low_limit_dec_pulse[0] |-> low_limit_dec_z1 inside {8'h02, 8'h04, 8'h06, 8'h08})
        else $error("zone 1 step not a coded value");
    a_refresh_pulse: assert property (tach_refresh_pulse[0] |=> !tach_refresh_pulse[0])
        else $error("refresh pulse longer than one cycle");

    c_write_acked: cover property (avs_write && !avs_waitrequest);
    c_dec_pulse: cover property (low_limit_dec_pulse[0]);
    c_refresh: cover property (tach_refresh_pulse[0]);
    c_snap: cover property (snap_off_now[1]);
endmodule : fan_opt_asserts

bind fan_tach_thermal_option_regs fan_opt_asserts fan_opt_asserts_i (.*);

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    import fan_opt_pkg::*;
    typedef struct { logic [7:0] a, rst, wd, exp; } row_s;
    logic        clk_sys         = 1'b0;
    logic        rst_n           = 1'b0;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'h1;
    logic        lock_in         = 1'b0;
    logic        supply_good     = 1'b1;
    logic [23:0] event_set       = 24'h0;
    logic [23:0] event_active    = 24'h0;
    logic [23:0] event_enable    = 24'hFFFFFF;
    logic [2:0]  enhanced_mode   = 3'h0;
    logic [2:0]  valid_reading   = 3'h0;
    logic [2:0]  drive_duty_zero = 3'h0;
    logic [2:0]  auto_low_limit_adjust = 3'h0;
    logic [7:0]  temp_zone1      = 8'h00;
    logic [7:0]  temp_zone2      = 8'h00;
    logic [7:0]  temp_zone3      = 8'h00;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  tach_refresh_pulse, snap_off_now, low_limit_dec_pulse;
    logic [5:0]  guard_ticks_ch1, guard_ticks_ch2, guard_ticks_ch3, speed_in_mode;
    logic [7:0]  low_limit_dec_z1, low_limit_dec_z2, low_limit_dec_z3;
    logic [7:0]  q;
    logic [7:0]  gt[4]  = '{8'h3F, 8'h20, 8'h10, 8'h08};
    int          n_mismatch  = 0;
    int          check_count = 0;
    int          n_ref[3]    = '{0, 0, 0};
    int          n_dec[3]    = '{0, 0, 0};
    int          base[3];
    row_s        rows[17] = '{
        '{8'h94, 8'h0C, 8'hFF, 8'h3F}, '{8'h95, 8'h0C, 8'hA5, 8'h25},
        '{8'h96, 8'h0C, 8'h00, 8'h00}, '{8'h97, 8'h5A, 8'h33, 8'h5A},
        '{8'h98, 8'hF1, 8'hCC, 8'hF1}, '{8'hA3, 8'h00, 8'h77, 8'h00},
        '{8'hA4, 8'h02, 8'hFF, 8'h02}, '{8'hA5, 8'h00, 8'hFF, 8'h00},
        '{8'hA6, 8'h00, 8'hFF, 8'h00}, '{8'hA7, 8'h00, 8'hFF, 8'h00},
        '{8'hAB, 8'h00, 8'hFF, 8'hFC}, '{8'hAD, 8'h00, 8'hFF, 8'h00},
        '{8'hAE, 8'h2D, 8'h40, 8'h40}, '{8'hAF, 8'h2D, 8'h41, 8'h41},
        '{8'hB3, 8'h2D, 8'h42, 8'h42}, '{8'hB4, 8'h00, 8'hFF, 8'hF0},
        '{8'h90, 8'h00, 8'hFF, 8'h00}};

    fan_tach_thermal_option_regs fan_tach_thermal_option_regs_i (.*);

    always #20 clk_sys = ~clk_sys;

    // pulses counted on the edge, before that edge's updates land
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 3; i++)
        begin
            n_ref[i] += int'(tach_refresh_pulse[i] === 1'b1);
            n_dec[i] += int'(low_limit_dec_pulse[i] === 1'b1);
        end
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    // request held until the rising edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            n_mismatch++;
            results();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg_%h", a), q, exp);
    endtask : rd

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i].a, rows[i].rst);
            if (!(rows[i].a inside {8'h97, 8'h98, 8'hA3}))
                wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, rows[i].exp);
        end
        enhanced_mode <= 3'b111;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h94, 8'(c << 3));
            repeat (2) @(posedge clk_sys);
            chk("guard_ticks_ch1", {2'b00, guard_ticks_ch1}, gt[c]);
            chk("guard_ticks_ch2", {2'b00, guard_ticks_ch2}, 8'h3F);
            chk("guard_ticks_ch3", {2'b00, guard_ticks_ch3}, 8'h3F);
        end
        enhanced_mode <= 3'b000;
        repeat (3) @(posedge clk_sys);
        chk("guard_ticks_ch1", {2'b00, guard_ticks_ch1}, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'hAB, {c[1:0], c[1:0], c[1:0], 2'b11});
            repeat (2) @(posedge clk_sys);
            chk("speed_in_mode", {2'b00, speed_in_mode}, {2'b00, c[1:0], c[1:0], c[1:0]});
        end
        drive_duty_zero <= 3'b111;
        repeat (3) @(posedge clk_sys);
        chk("snap_off_now", {5'h00, snap_off_now}, 8'h02);
        wr(8'h94, 8'h24);
        repeat (2) @(posedge clk_sys);
        chk("snap_off_now", {5'h00, snap_off_now}, 8'h03);
        drive_duty_zero <= 3'b000;
        enhanced_mode   <= 3'b101;
        repeat (3) @(posedge clk_sys);
        base = n_ref;
        valid_reading <= 3'b101;
        @(posedge clk_sys);
        valid_reading <= 3'b000;
        repeat (4) @(posedge clk_sys);
        chk("refresh_ch1", 8'(n_ref[0] - base[0]), 8'h01);
        chk("refresh_ch3", 8'(n_ref[2] - base[2]), 8'h00);
        temp_zone1 <= 8'h3F;
        temp_zone2 <= 8'h41;
        temp_zone3 <= 8'h50;
        auto_low_limit_adjust <= 3'b011;
        repeat (4) @(posedge clk_sys);
        base = n_dec;
        temp_zone1 <= 8'h40;
        temp_zone2 <= 8'h42;
        repeat (6) @(posedge clk_sys);
        chk("dec_zone1", 8'(n_dec[0] - base[0]), 8'h01);
        chk("dec_zone2", 8'(n_dec[1] - base[1]), 8'h01);
        chk("dec_zone3", 8'(n_dec[2] - base[2]), 8'h00);
        chk("low_limit_dec_z1", low_limit_dec_z1, 8'h08);
        chk("low_limit_dec_z2", low_limit_dec_z2, 8'h02);
        chk("low_limit_dec_z3", low_limit_dec_z3, 8'h08);
        event_active <= 24'h000010;
        event_set    <= 24'h018090;
        @(posedge clk_sys);
        event_set <= 24'h000000;
        rd(8'hA5, 8'h90);
        wr(8'hA5, 8'hFF);
        rd(8'hA5, 8'h90);
        event_active <= 24'h000000;
        wr(8'hA5, 8'h00);
        rd(8'hA5, 8'h90);
        wr(8'hA5, 8'hFF);
        rd(8'hA5, 8'h80);
        wr(8'hA6, 8'h80);
        rd(8'hA6, 8'h00);
        rd(8'hA7, 8'h01);
        event_enable <= 24'hFEFFFF;
        repeat (2) @(posedge clk_sys);
        rd(8'hA7, 8'h00);
        event_enable <= 24'hFFFFFF;
        wr(8'hAE, 8'h11);
        event_set <= 24'h000100;
        @(posedge clk_sys);
        event_set   <= 24'h000000;
        supply_good <= 1'b0;
        repeat (5) @(posedge clk_sys);
        supply_good <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(8'hA5, 8'h00);
        rd(8'hA6, 8'h00);
        rd(8'hAE, 8'h2D);
        lock_in <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wr(8'h94, 8'h3F);
        rd(8'h94, 8'h24);
        wr(8'hAE, 8'h55);
        rd(8'hAE, 8'h2D);
        wr(8'hB4, 8'h00);
        rd(8'hB4, 8'hF0);
        lock_in <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wr(8'h95, 8'h00);
        rd(8'h95, 8'h25);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h94, 8'h0C);
        wr(8'h94, 8'h01);
        rd(8'h94, 8'h01);
        results();
    end
endmodule : testbench
